// [hw/general_timer.sv]
// six-channel 16-bit timer/event counter with register port, compare/capture and outputs
`timescale 1ns/1ps
module general_timer
  import timer_pkg::*;
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          srst,
  // register port
  input  wire logic [timer_pkg::ADDR_W-1:0]  addr,
  input  wire logic [timer_pkg::DATA_W-1:0]  write_data,
  input  wire logic [timer_pkg::DATA_W-1:0]  write_mask,
  input  wire logic                          write_strobe,
  input  wire logic                          read_strobe,
  output logic      [timer_pkg::DATA_W-1:0]  read_data,
  // timer input pins, one bit per channel
  input  wire logic [timer_pkg::NUM_CH-1:0]  timer_input_0,
  input  wire logic [timer_pkg::NUM_CH-1:0]  timer_input_1,
  // timer output pins, one bit per channel
  output logic      [timer_pkg::NUM_CH-1:0]  timer_output_0,
  output logic      [timer_pkg::NUM_CH-1:0]  timer_output_1,
  // match or capture requests, one-cycle pulses
  output logic      [timer_pkg::NUM_CH-1:0]  match_irq_0,
  output logic      [timer_pkg::NUM_CH-1:0]  match_irq_1
);
  import timer_pkg::*;

  // masked byte merge, lets software touch a single bit
  function automatic logic [7:0] merge8(input logic [7:0] old_v, input logic [7:0] new_v,
                                        input logic [7:0] msk);
    merge8 = (old_v & ~msk) | (new_v & msk);
  endfunction

  // masked halfword merge for the compare registers
  function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old_v,
                                               input logic [CNT_W-1:0] new_v,
                                               input logic [CNT_W-1:0] msk);
    merge16 = (old_v & ~msk) | (new_v & msk);
  endfunction

  // valid edge filter: bit 0 passes rising, bit 1 passes falling
  function automatic logic edge_ok(input logic [1:0] sel, input logic rise, input logic fall);
    edge_ok = (sel[0] & rise) | (sel[1] & fall);
  endfunction

  // shared prescaler and its all-ones taps
  logic [PRESC_W-1:0]     presc_r;               // free-running divider
  logic [PRESC_W:0]       tap_ones;              // tap k high once every 2^k cycles
  // per-channel bus decode and read data
  logic [NUM_CH-1:0]      ch_hit;                // address falls in channel block
  logic [DATA_W-1:0]      rd_ch [NUM_CH];        // channel read value, zero if not hit
  logic [DATA_W-1:0]      rd_sel;                // or of all channel read values
  logic [DATA_W-1:0]      read_data_r;           // registered read answer
  logic [3:0]             sub_ofs;               // register offset inside a block
  logic [7:0]             wd8;                   // low byte of write data
  logic [7:0]             wm8;                   // low byte of write mask

  assign sub_ofs = addr[BASE_LSB-1:0];
  assign wd8     = write_data[7:0];
  assign wm8     = write_mask[7:0];

  // prescaler runs from reset onward, shared by all channels
  always_ff @(posedge clk)
  begin
    if (srst)
      presc_r <= '0;
    else
      presc_r <= presc_r + 9'h001;
  end

  // tap zero is the undivided clock
  assign tap_ones[0] = 1'b1;
  generate
    for (genvar k = 1; k <= PRESC_W; k++)
    begin : g_tap
      assign tap_ones[k] = &presc_r[k-1:0];      // divide by 2^k
    end
  endgenerate

  // one channel per index, alike except the odd-channel taps
  generate
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
      localparam bit ODD = (g % 2) == 1;         // odd channels use deeper top taps

      // input synchronisers and edge history
      logic [1:0]        in0_sync_r;             // stage 0 feeds stage 1 only
      logic [1:0]        in1_sync_r;
      logic              in0_prev_r;             // last synchronised level
      logic              in1_prev_r;
      // software registers
      logic [7:0]        ctl0_r;                 // run enable and clock select
      logic [7:0]        ctl1_r;                 // event enable and mode
      logic [7:0]        ioc0_r;                 // output enables and levels
      logic [7:0]        ioc1_r;                 // capture edges of both inputs
      logic [7:0]        ioc2_r;                 // event and trigger edges of input 0
      logic              ovf_r;                  // overflow flag
      logic [1:0]        ccs_r;                  // compare/capture select
      logic [CNT_W-1:0]  ccr0_r;                 // capture_compare_reg_0
      logic [CNT_W-1:0]  ccr1_r;                 // capture_compare_reg_1
      logic [CNT_W-1:0]  buf0_r;                 // hidden compare buffer 0
      logic [CNT_W-1:0]  buf1_r;                 // hidden compare buffer 1
      // counting core
      logic [CNT_W-1:0]  cnt_r;                  // 16-bit counter
      logic [CNT_W-1:0]  cnt_nxt;
      run_state_e        state_r;                // waiting for trigger or counting
      run_state_e        state_nxt;
      logic              started_r;              // first edge after enable seen
      logic              act0_r;                 // active phase of output 0
      logic              act1_r;                 // active phase of output 1
      logic              out0_r;                 // pin registers
      logic              out1_r;
      logic              irq0_r;                 // request pulses
      logic              irq1_r;

      // decode of this block
      logic        wr_ctl0, wr_ctl1, wr_ioc0, wr_ioc1, wr_ioc2, wr_opt0, wr_ccr0, wr_ccr1;
      logic [7:0]  ctl0_nxt;                     // merged control 0 value
      logic [7:0]  ctl1_mrg;                     // merged control 1 value incl. trigger bit
      logic        run;                          // run enable
      mode_e       mode;                         // selected operating mode
      logic [2:0]  cks;                          // clock select code
      logic [3:0]  div_shift;                    // decoded divider exponent
      logic        rise0, fall0, rise1, fall1;   // synchronised input edges
      logic        ev_edge, trg_edge, cap0_edge, cap1_edge;
      logic        ext_src, tick, trig_mode, est_wr, trigger, restart;
      logic        cap0_mode, cap1_mode, clear_at0, pulse_out;
      logic        counting, eq0, eq1, match0, match1, ovf_set, cap0, cap1;

      assign ch_hit[g] = addr[ADDR_W-1:BASE_LSB] == CH_BASE[g][ADDR_W-1:BASE_LSB];
      assign wr_ctl0   = write_strobe & ch_hit[g] & (sub_ofs == OFS_CTL0);
      assign wr_ctl1   = write_strobe & ch_hit[g] & (sub_ofs == OFS_CTL1);
      assign wr_ioc0   = write_strobe & ch_hit[g] & (sub_ofs == OFS_IOC0);
      assign wr_ioc1   = write_strobe & ch_hit[g] & (sub_ofs == OFS_IOC1);
      assign wr_ioc2   = write_strobe & ch_hit[g] & (sub_ofs == OFS_IOC2);
      assign wr_opt0   = write_strobe & ch_hit[g] & (sub_ofs == OFS_OPT0);
      assign wr_ccr0   = write_strobe & ch_hit[g] & (sub_ofs == OFS_CCR0);
      assign wr_ccr1   = write_strobe & ch_hit[g] & (sub_ofs == OFS_CCR1);

      // byte or single bit writes; reserved bits never stored
      assign ctl0_nxt = merge8(ctl0_r, wd8, wm8) & CTL0_WMASK;
      assign ctl1_mrg = merge8(ctl1_r, wd8, wm8);

      assign run  = ctl0_r[CTL0_CE];
      assign mode = mode_e'(ctl1_r[2:0]);
      assign cks  = ctl0_r[2:0];

      // clock select: top two codes are four times deeper on odd channels
      assign div_shift = (ODD && (cks >= CKS_HIGH)) ? ({1'b0, cks} + ODD_SHIFT_ADD)
                                                     : {1'b0, cks};

      // edges of the synchronised pins
      assign rise0 = in0_sync_r[1] & ~in0_prev_r;
      assign fall0 = ~in0_sync_r[1] & in0_prev_r;
      assign rise1 = in1_sync_r[1] & ~in1_prev_r;
      assign fall1 = ~in1_sync_r[1] & in1_prev_r;

      // input 0 serves as event, trigger or capture input
      assign ev_edge   = edge_ok(ioc2_r[1:0], rise0, fall0);
      assign trg_edge  = edge_ok(ioc2_r[3:2], rise0, fall0);
      assign cap0_edge = edge_ok(ioc1_r[1:0], rise0, fall0);
      assign cap1_edge = edge_ok(ioc1_r[3:2], rise1, fall1);

      // count source: prescaled clock or external event
      assign ext_src = (mode == MODE_EVENT) | ctl1_r[CTL1_EEE];
      assign tick    = run & (ext_src ? ev_edge : tap_ones[div_shift]);

      // trigger modes accept pin edge or software trigger
      assign trig_mode = (mode == MODE_EXT_TRIG) | (mode == MODE_ONE_SHOT);
      assign est_wr    = wr_ctl1 & ctl1_mrg[CTL1_EST];
      assign trigger   = run & trig_mode & (trg_edge | est_wr);
      assign restart   = trigger & ((state_r == ST_WAIT) | (mode == MODE_EXT_TRIG));

      // capture use of the two registers
      assign cap0_mode = (mode == MODE_PULSE) | ((mode == MODE_FREE_RUN) & ccs_r[0]);
      assign cap1_mode = (mode == MODE_PULSE) | ((mode == MODE_FREE_RUN) & ccs_r[1]);
      assign clear_at0 = (mode != MODE_FREE_RUN) & (mode != MODE_PULSE);
      assign pulse_out = (mode == MODE_EXT_TRIG) | (mode == MODE_ONE_SHOT) |
                         (mode == MODE_PWM);

      // compare against the hidden buffers
      assign counting = run & (state_r == ST_RUN);
      assign eq0      = cnt_r == buf0_r;
      assign eq1      = cnt_r == buf1_r;
      assign match0   = tick & counting & eq0 & ~cap0_mode;
      assign match1   = tick & counting & eq1 & ~cap1_mode;
      assign cap0     = run & cap0_mode & cap0_edge;
      assign cap1     = run & cap1_mode & cap1_edge;
      assign ovf_set  = tick & counting & started_r & (cnt_r == CNT_IDLE);

      // counter next value
      always_comb
      begin
        cnt_nxt = cnt_r;
        if (!run)
          cnt_nxt = CNT_IDLE;
        else if (restart)
          cnt_nxt = CNT_IDLE;                                 // next edge gives zero
        else if ((mode == MODE_PULSE) && cap0)
          cnt_nxt = tick ? CNT_ONE : CNT_ZERO;                // width restarts at edge
        else if (tick && counting)
        begin
          if (clear_at0 && eq0)
            cnt_nxt = CNT_ZERO;                               // period end at buffer 0
          else
            cnt_nxt = cnt_r + CNT_ONE;                        // all ones wraps to zero
        end
      end

      // counting state: triggered modes wait, others run once enabled
      always_comb
      begin
        state_nxt = state_r;
        case (state_r)
          ST_WAIT:
          begin
            if (run && (!trig_mode || restart))
              state_nxt = ST_RUN;
          end
          ST_RUN:
          begin
            if (!run)
              state_nxt = ST_WAIT;
            else if ((mode == MODE_ONE_SHOT) && match0)
              state_nxt = ST_WAIT;                            // single pulse done
          end
          default:
            state_nxt = ST_WAIT;
        endcase
      end

      // pin synchronisers, two flops before any logic
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          in0_sync_r <= 2'h0;
          in1_sync_r <= 2'h0;
          in0_prev_r <= 1'b0;
          in1_prev_r <= 1'b0;
        end
        else
        begin
          in0_sync_r <= {in0_sync_r[0], timer_input_0[g]};
          in1_sync_r <= {in1_sync_r[0], timer_input_1[g]};
          in0_prev_r <= in0_sync_r[1];
          in1_prev_r <= in1_sync_r[1];
        end
      end

      // configuration registers, reset to zero
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          ctl0_r <= REG_RST;
          ctl1_r <= REG_RST;
          ioc0_r <= REG_RST;
          ioc1_r <= REG_RST;
          ioc2_r <= REG_RST;
          ccs_r  <= 2'h0;
        end
        else
        begin
          if (wr_ctl0)
            ctl0_r <= ctl0_nxt;                               // same value rewrite is inert
          if (wr_ctl1)
            ctl1_r <= ctl1_mrg & CTL1_WMASK;
          if (wr_ioc0)
            ioc0_r <= merge8(ioc0_r, wd8, wm8) & IOC_WMASK;
          if (wr_ioc1)
            ioc1_r <= merge8(ioc1_r, wd8, wm8) & IOC_WMASK;
          if (wr_ioc2)
            ioc2_r <= merge8(ioc2_r, wd8, wm8) & IOC_WMASK;
          if (wr_opt0)
            ccs_r  <= {wm8[OPT0_CS1] ? wd8[OPT0_CS1] : ccs_r[1],
                       wm8[OPT0_CS0] ? wd8[OPT0_CS0] : ccs_r[0]};
        end
      end

      // overflow flag: disable clears, hardware set beats software clear
      always_ff @(posedge clk)
      begin
        if (srst)
          ovf_r <= 1'b0;
        else if (!run)
          ovf_r <= 1'b0;
        else if (ovf_set)
          ovf_r <= 1'b1;
        else if (wr_opt0 && wm8[OPT0_OVF])
          ovf_r <= wd8[OPT0_OVF];
      end

      // capture/compare registers and hidden buffers
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          ccr0_r <= CCR_RST;
          ccr1_r <= CCR_RST;
          buf0_r <= CCR_RST;
          buf1_r <= CCR_RST;
        end
        else
        begin
          if (cap0)
            ccr0_r <= cnt_r;                                  // capture wins over write
          else if (wr_ccr0)
            ccr0_r <= merge16(ccr0_r, write_data, write_mask);
          if (cap1)
            ccr1_r <= cnt_r;
          else if (wr_ccr1)
            ccr1_r <= merge16(ccr1_r, write_data, write_mask);
          if (wr_ccr0 && !cap0_mode)
            buf0_r <= merge16(ccr0_r, write_data, write_mask);
          if (wr_ccr1 && !cap1_mode)
            buf1_r <= merge16(ccr1_r, write_data, write_mask);
        end
      end

      // counter, state and enable history
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          cnt_r     <= CNT_IDLE;
          state_r   <= ST_WAIT;
          started_r <= 1'b0;
        end
        else
        begin
          cnt_r     <= cnt_nxt;
          state_r   <= state_nxt;
          started_r <= run & (started_r | (tick & counting));
        end
      end

      // output controller and requests
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          act0_r <= 1'b0;
          act1_r <= 1'b0;
          out0_r <= 1'b0;
          out1_r <= 1'b0;
          irq0_r <= 1'b0;
          irq1_r <= 1'b0;
        end
        else
        begin
          if (!run || restart)
            act0_r <= 1'b0;
          else if (match0)
            act0_r <= ~act0_r;                                // square wave at period
          if (!run || restart)
            act1_r <= 1'b0;
          else if (pulse_out)
            act1_r <= match1 | (act1_r & ~match0);            // active from ccr1 to ccr0
          else if (match1)
            act1_r <= ~act1_r;
          out0_r <= ioc0_r[IOC0_OL0] ^ (ioc0_r[IOC0_OE0] & act0_r);
          out1_r <= ioc0_r[IOC0_OL1] ^ (ioc0_r[IOC0_OE1] & act1_r);
          irq0_r <= match0 | cap0;
          irq1_r <= match1 | cap1;
        end
      end

      // read value of this block; stopped counter reads zero
      always_comb
      begin
        rd_ch[g] = '0;
        if (ch_hit[g])
        begin
          case (sub_ofs)
            OFS_CTL0: rd_ch[g] = {8'h00, ctl0_r};
            OFS_CTL1: rd_ch[g] = {8'h00, ctl1_r};
            OFS_IOC0: rd_ch[g] = {8'h00, ioc0_r};
            OFS_IOC1: rd_ch[g] = {8'h00, ioc1_r};
            OFS_IOC2: rd_ch[g] = {8'h00, ioc2_r};
            OFS_OPT0: rd_ch[g] = {10'h000, ccs_r, 3'h0, ovf_r};
            OFS_CCR0: rd_ch[g] = ccr0_r;
            OFS_CCR1: rd_ch[g] = ccr1_r;
            OFS_CNT:  rd_ch[g] = run ? cnt_r : CNT_ZERO;
            default:  rd_ch[g] = '0;
          endcase
        end
      end

      assign timer_output_0[g] = out0_r;
      assign timer_output_1[g] = out1_r;
      assign match_irq_0[g]    = irq0_r;
      assign match_irq_1[g]    = irq1_r;
    end
  endgenerate

  // gather the read value, unmapped addresses read zero
  always_comb
  begin
    rd_sel = '0;
    for (int i = 0; i < NUM_CH; i++)
      rd_sel = rd_sel | rd_ch[i];
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (srst)
      read_data_r <= '0;
    else if (read_strobe)
      read_data_r <= rd_sel;
    else
      read_data_r <= '0;
  end

  assign read_data = read_data_r;

endmodule // general_timer

// [include/timer_pkg.sv]
// shared constants, register map and types for the six-channel timer/event counter
package timer_pkg;
  // structure
  localparam int NUM_CH   = 6;                   // number of channels, alike except deeper top taps on odd ones
  localparam int CNT_W    = 16;                  // counter and compare width
  localparam int ADDR_W   = 32;                  // bus address width
  localparam int DATA_W   = 16;                  // bus data width
  localparam int PRESC_W  = 9;                   // prescaler bits, deepest tap is /512
  // channel base addresses, one control block of sixteen bytes each
  localparam logic [ADDR_W-1:0] CH_BASE [NUM_CH] = '{
    32'hFFFFF590, 32'h0FFFF5A0, 32'hFFFFF5B0,
    32'hFFFFF5C0, 32'hFFFFF5D0, 32'hFFFFF5E0};
  localparam int BASE_LSB = 4;                   // bits below this select the register
  // register offsets inside a channel block
  localparam logic [3:0] OFS_CTL0 = 4'h0;        // control_reg_0
  localparam logic [3:0] OFS_CTL1 = 4'h1;        // mode and count source control
  localparam logic [3:0] OFS_IOC0 = 4'h2;        // output_control_reg
  localparam logic [3:0] OFS_IOC1 = 4'h3;        // edge_select_reg_a
  localparam logic [3:0] OFS_IOC2 = 4'h4;        // edge_select_reg_b
  localparam logic [3:0] OFS_OPT0 = 4'h5;        // option_reg
  localparam logic [3:0] OFS_CCR0 = 4'h6;        // capture_compare_reg_0
  localparam logic [3:0] OFS_CCR1 = 4'h8;        // capture_compare_reg_1
  localparam logic [3:0] OFS_CNT  = 4'hA;        // counter_read_buffer
  // field positions
  localparam int CTL0_CE  = 7;                   // run_enable_bit
  localparam int CTL1_EST = 6;                   // software trigger, write-only pulse
  localparam int CTL1_EEE = 5;                   // external event count enable
  localparam int IOC0_OE0 = 0;                   // output 0 enable
  localparam int IOC0_OL0 = 1;                   // output 0 level invert
  localparam int IOC0_OE1 = 2;                   // output 1 enable
  localparam int IOC0_OL1 = 3;                   // output 1 level invert
  localparam int OPT0_OVF = 0;                   // overflow_flag
  localparam int OPT0_CS0 = 4;                   // ccr0 used for capture
  localparam int OPT0_CS1 = 5;                   // ccr1 used for capture
  // writable bit masks, other bits read as zero
  localparam logic [7:0] CTL0_WMASK = 8'h87;
  localparam logic [7:0] CTL1_WMASK = 8'h27;
  localparam logic [7:0] IOC_WMASK  = 8'h0F;
  // reset and idle values
  localparam logic [7:0]       REG_RST   = 8'h00;
  localparam logic [CNT_W-1:0] CCR_RST   = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_IDLE  = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
  // clock select decode
  localparam logic [2:0] CKS_HIGH      = 3'h6;   // first code that differs on odd channels
  localparam logic [3:0] ODD_SHIFT_ADD = 4'h2;   // odd channels divide four times deeper
  // operating modes
  typedef enum logic [2:0] {
    MODE_INTERVAL = 3'h0,
    MODE_EVENT    = 3'h1,
    MODE_EXT_TRIG = 3'h2,
    MODE_ONE_SHOT = 3'h3,
    MODE_PWM      = 3'h4,
    MODE_FREE_RUN = 3'h5,
    MODE_PULSE    = 3'h6,
    MODE_RSVD     = 3'h7
  } mode_e;
  // counting state of a channel
  typedef enum logic [0:0] {
    ST_WAIT = 1'h0,
    ST_RUN  = 1'h1
  } run_state_e;
endpackage

// [tb/timer_sva.sv]
// channel 0 checker for the timer, bound to the top module
`timescale 1ns/1ps
module timer_sva (
  // clock, reset, register port
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [31:0] addr,
  input wire logic [15:0] write_data,
  input wire logic [15:0] write_mask,
  input wire logic        write_strobe,
  input wire logic        read_strobe,
  input wire logic [15:0] read_data,
  // pins and requests
  input wire logic [5:0]  timer_output_0,
  input wire logic [5:0]  timer_output_1,
  input wire logic [5:0]  match_irq_0,
  input wire logic [5:0]  match_irq_1
);
  import timer_pkg::*;
  logic [7:0]  ctl_r;  // control_reg_0 shadow
  logic [15:0] ccr_r;  // ccr0 shadow
  wire ctl_hit = addr == CH_BASE[0];
  wire ccr_hit = addr == {CH_BASE[0][31:4], OFS_CCR0};
  wire cnt_hit = addr == {CH_BASE[0][31:4], OFS_CNT};
  wire [7:0]  ctl_nxt = ((ctl_r & ~write_mask[7:0]) | (write_data[7:0] & write_mask[7:0]))
                        & 8'h87;
  wire [15:0] ccr_nxt = (ccr_r & ~write_mask) | (write_data & write_mask);
  wire run = ctl_r[7];
  wire fast = run && ctl_r[2:0] == 3'h0 && ccr_r == 16'h0002;  // div1, compare at 2
  wire quiet = !write_strobe || (ctl_hit && ctl_nxt == ctl_r);  // no write but same-value rewrite
  // shadows follow software writes
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctl_r <= 8'h00;
      ccr_r <= 16'h0000;
    end
    else if (write_strobe && ctl_hit) ctl_r <= ctl_nxt;
    else if (write_strobe && ccr_hit) ccr_r <= ccr_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  rd_idle_a: assert property (!$past(read_strobe) |-> read_data == 16'h0000)
    else $error("read data outside read cycle");
  rst_quiet_a: assert property ($fell(srst) |-> !(|{read_data, timer_output_0,
    timer_output_1, match_irq_0, match_irq_1})) else $error("outputs after reset");
  ctl_back_a: assert property (read_strobe && ctl_hit |=> read_data == {8'h00, ctl_r})
    else $error("control readback");
  ccr_back_a: assert property (read_strobe && ccr_hit |=> read_data == ccr_r)
    else $error("compare readback");
  cnt_stop_a: assert property (read_strobe && cnt_hit && !run |=> read_data == 16'h0000)
    else $error("stopped counter read");
  stop_quiet_a: assert property (!run && !$past(run) |->
    !match_irq_0[0] && !match_irq_1[0]) else $error("request while stopped");
  start_match_a: assert property ($rose(run) && fast |-> ##[4:6] match_irq_0[0])
    else $error("first match late");
  match_period_a: assert property (match_irq_0[0] && fast && quiet ##1 quiet[*2] |=>
    match_irq_0[0]) else $error("match period");
  cover property (match_irq_0[0] && fast);
  cover property (match_irq_1[0]);
  cover property (read_strobe && cnt_hit && !run);
endmodule // timer_sva
bind general_timer timer_sva chk (.clk(clk), .srst(srst), .addr(addr), .write_data(write_data),
  .write_mask(write_mask), .write_strobe(write_strobe), .read_strobe(read_strobe),
  .read_data(read_data), .timer_output_0(timer_output_0), .timer_output_1(timer_output_1),
  .match_irq_0(match_irq_0), .match_irq_1(match_irq_1));

// [tb/tb_top.sv]
// self-checking testbench for the six-channel timer
`timescale 1ns/1ps
module tb_top;
  import timer_pkg::*;
  logic        clk = 0, srst = 1, ws = 0, rs = 0;  // clock, reset, strobes
  logic [31:0] addr = '0;                          // register address
  logic [15:0] wd = '0, wm = '0, rdat, q;          // bus data
  logic [5:0]  ti0 = '0, ti1 = '0, to0, to1, mi0, mi1;  // pins and requests
  int miscompares = 0, num_checks = 0, n, ev;
  general_timer uut (.clk(clk), .srst(srst), .addr(addr), .write_data(wd), .write_mask(wm),
    .write_strobe(ws), .read_strobe(rs), .read_data(rdat), .timer_input_0(ti0),
    .timer_input_1(ti1), .timer_output_0(to0), .timer_output_1(to1),
    .match_irq_0(mi0), .match_irq_1(mi1));
  // 50 ns clock
  initial forever #25 clk = ~clk;
  // event request counter, channel 2
  always @(posedge clk) if (mi0[2] === 1'b1) ev++;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [15:0] d, input logic [15:0] m);
    @(posedge clk);
    {addr, wd, wm, ws} <= {a, d, m, 1'b1};
    @(posedge clk);
    ws <= 0;
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge clk);
    {addr, rs} <= {a, 1'b1};
    @(posedge clk);
    rs <= 0;
    #1 q = rdat;
  endtask
  // wait for a request of channel c, bounded
  task automatic wait_irq(input int c, input bit s);
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
      if (n > 1100)
      begin
        miscompares++;
        stop_test();
      end
    end while ((s ? mi1[c] : mi0[c]) !== 1'b1);
  endtask
  function automatic logic [31:0] ra(input int c, input logic [3:0] o);
    return {CH_BASE[c][31:4], o};
  endfunction
  // address, write data, write mask, readback
  logic [79:0] rows [7] = '{{ra(0, 0), 48'h0007_00FF_0007}, {ra(1, 0), 48'h0005_0005_0005},
    {ra(4, 0), 48'h0080_0080_0080}, {ra(2, 6), 48'h1234_FFFF_1234},
    {ra(3, 8), 48'hABCD_FFFF_ABCD}, {ra(3, 1), 48'h0040_00FF_0000},
    {32'h0000_1000, 48'hFFFF_FFFF_0000}};
  initial
  begin
    repeat (12) @(posedge clk);
    srst <= 0;
    rd(ra(5, 0)); chk("ctl0 reset", 16'h0000, q);
    rd(ra(5, 6)); chk("ccr0 reset", 16'h0000, q);
    rd(ra(5, 8)); chk("ccr1 reset", 16'h0000, q);
    rd(ra(5, 10)); chk("stopped count", 16'h0000, q);
    foreach (rows[i])
    begin
      wr(rows[i][79:48], rows[i][47:32], rows[i][31:16]);
      rd(rows[i][79:48]); chk("readback", rows[i][15:0], q);
    end
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 8; k++)
      begin
        wr(ra(c, 0), 16'h0000, 16'h00FF);
        wr(ra(c, 6), 16'h0000, 16'hFFFF);
        wr(ra(c, 0), 16'(8'h80 + k), 16'h00FF);
        wait_irq(c, 0);
        wait_irq(c, 0);
        chk("tick period", 16'(1 << (k + (c == 1 && k > 5 ? 2 : 0))), 16'(n));
      end
    wr(ra(0, 0), 16'h0000, 16'h00FF);
    wr(ra(0, 6), 16'h0002, 16'hFFFF);
    wr(ra(0, 0), 16'h0080, 16'h0080);
    wait_irq(0, 0);
    wr(ra(0, 0), 16'h0080, 16'h00FF);
    wait_irq(0, 0);
    chk("match after rewrite", 16'h0001, 16'(n));
    wait_irq(0, 0);
    chk("period after rewrite", 16'h0003, 16'(n));
    wr(ra(0, 8), 16'h0001, 16'hFFFF);
    wait_irq(0, 1);
    chk("ccr0 beside ccr1", 16'h0000, 16'(mi0[0]));
    wait_irq(0, 0);
    chk("ccr1 ahead of ccr0", 16'h0001, 16'(n));
    wr(ra(0, 0), 16'h0000, 16'h0080);
    rd(ra(0, 10)); chk("count after stop", 16'h0000, q);
    wr(ra(2, 1), 16'h0001, 16'h00FF);
    wr(ra(2, 4), 16'h0001, 16'h00FF);
    wr(ra(2, 6), 16'h0000, 16'hFFFF);
    wr(ra(2, 0), 16'h0080, 16'h00FF);
    ev = 0;
    repeat (3)
    begin
      @(posedge clk) ti0[2] <= 1;
      repeat (6) @(posedge clk);
      ti0[2] <= 0;
      repeat (6) @(posedge clk);
    end
    chk("event requests", 16'h0002, 16'(ev));
    wr(ra(3, 2), 16'h000A, 16'h00FF);
    repeat (2) @(posedge clk);
    #1 chk("idle output level", 16'h0001, 16'(to0[3]));
    chk("idle output 1 level", 16'h0001, 16'(to1[3]));
    stop_test();
  end
  // run limit
  initial
  begin
    #5000000;
    miscompares++;
    stop_test();
  end
endmodule // tb_top
